// ===== design/tcl_defs.svh
// offsets, field positions, reset values and timing counts of the calibration loader
`ifndef TCL_DEFS_SVH
`define TCL_DEFS_SVH
// timing
`define TCL_CLK_PERIOD_NS 5
`define TCL_REFRESH_UNIT_NS 1000000
// flash map, byte addresses
`define TCL_OFS_BASE 11'h000
`define TCL_OFS_LAST 11'h15F
`define TCL_SPAN_BASE 11'h200
`define TCL_SPAN_LAST 11'h35F
`define TCL_CFG1_ADDR 11'h160
`define TCL_CFG2_ADDR 11'h162
`define TCL_OTC_ADDR 11'h166
`define TCL_STC_ADDR 11'h16A
`define TCL_PWRUP_ADDR 11'h16C
`define TCL_USER_BASE 11'h700
`define TCL_USER_BYTES 256
`define TCL_TABLE_ENTRIES 176
`define TCL_INDEX_MAX 8'hAF
// second config word: refresh interval select field
`define TCL_CFG2_REFR_LSB 0
`define TCL_CFG2_REFR_MSB 1
// reset values
`define TCL_CFG2_RST 16'h0002
`define TCL_WORD_RST 16'h0000
`define TCL_CTRL_RST 5'h01
// register byte offsets
`define TCL_REG_CTRL 8'h00
`define TCL_REG_STATUS 8'h04
`define TCL_REG_BANK 8'h08
`define TCL_REG_INDEX 8'h24
`define TCL_BANK_WORDS 7
// control bits
`define TCL_CTRL_RUN 0
`define TCL_CTRL_SERIAL 1
`define TCL_CTRL_DRIVE 2
`define TCL_CTRL_PIN_OUT 3
`define TCL_CTRL_RELOAD 4
// bus responses
`define TCL_RESP_OKAY 2'h0
`define TCL_RESP_SLVERR 2'h2
`endif

// ===== design/tcl_flash_word_rd.sv
// reads one 16-bit word from byte-wide flash, low byte first
`timescale 1ns/1ps
module tcl_flash_word_rd import tcl_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // word request
  input wire logic start,
  input wire logic [10:0] byte_addr,
  output logic [15:0] word,
  output logic done,
  // flash byte port
  output logic flash_req,
  output logic [10:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_ack
);
  logic high_q;
  logic [7:0] low_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_req <= 1'b0;
      flash_addr <= 11'h000;
      high_q <= 1'b0;
      low_q <= 8'h00;
      word <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !flash_req) begin
        flash_req <= 1'b1;
        flash_addr <= {byte_addr[10:1], 1'b0};
        high_q <= 1'b0;
      end else if (flash_req && flash_ack && !high_q) begin
        low_q <= flash_rdata;
        flash_addr <= {flash_addr[10:1], 1'b1};
        high_q <= 1'b1;
      end else if (flash_req && flash_ack) begin
        flash_req <= 1'b0;
        word <= {flash_rdata, low_q};
        done <= 1'b1;
      end
    end
  end
endmodule

// ===== design/tcl_loader.sv
// temperature-indexed calibration loader with its register file
`timescale 1ns/1ps
`include "tcl_defs.svh"
// Functional notes
// - each refresh loads offset entry at index
// - offset table holds 176 sixteen-bit entries
// - span table, same index, feeds span code
// - span code sets excitation; tempco in current mode
// - one conversion per interval, stored as index
// - index is truncated eight-bit integer
// - all four codes take any 16-bit value
// - config, tables, tempco kept as flash words
// - 256 user bytes never touched by loader
// - config bit swaps bridge inputs
// - config field picks one of four ratios
// - gain picked from 32 steps
// - shared pin: analog or serial, never both
// - index saturates between 0x00 and 0xAF
// - tables at 0x000-0x15F and 0x200-0x35F
// - low byte even address, high byte odd
module tcl_loader import tcl_pkg::*; #(
  parameter int unsigned REFRESH_UNIT_CYC = `TCL_REFRESH_UNIT_NS / `TCL_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // flash byte port
  output logic flash_req,
  output logic [10:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_ack,
  // temperature adc
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [7:0] adc_result,
  // analog settings
  output tcl_dac_codes_t dac_codes,
  output logic [4:0] gain_step,
  output logic swap_inputs,
  output logic [1:0] current_mirror_ratio_sel,
  output logic span_tempco_to_excitation,
  output logic [15:0] power_up_setup_word,
  // shared output pin
  input wire logic shared_output_serial_pin_i,
  output logic shared_output_serial_pin_o,
  output logic shared_output_serial_pin_oe,
  output logic analog_output_en
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  tcl_state_t state_q;
  logic [2:0] step_q;
  logic [7:0] index_q;
  logic rd_start_q;
  logic [10:0] rd_addr_q;
  logic [15:0] rd_word;
  logic rd_done;
  logic tick;
  logic boot_q;
  logic loaded_q;
  logic [4:0] ctrl_q;
  logic run_prev_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic [15:0] bank_q [`TCL_BANK_WORDS];
  logic [`TCL_BANK_WORDS-1:0] ld_we;
  logic [`TCL_BANK_WORDS-1:0] sw_we;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  tcl_cfg1_t cfg1;

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  tcl_refresh_timer #(
    .UNIT_CYC(REFRESH_UNIT_CYC)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl_q[`TCL_CTRL_RUN]),
    .sel(bank_q[1][`TCL_CFG2_REFR_MSB:`TCL_CFG2_REFR_LSB]),
    .tick(tick)
  );

  tcl_flash_word_rd u_rd (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rd_start_q),
    .byte_addr(rd_addr_q),
    .word(rd_word),
    .done(rd_done),
    .flash_req(flash_req),
    .flash_addr(flash_addr),
    .flash_rdata(flash_rdata),
    .flash_ack(flash_ack)
  );

  ////////////////////////////////////////////////////////////////////////////
  // loader decode
  logic [7:0] index_sat;
  logic [10:0] ofs_addr;
  logic [10:0] span_addr;
  logic [10:0] cfg_addr;
  logic [2:0] cfg_slot;
  logic reload_req;
  logic run_rise;

  assign index_sat = (adc_result > `TCL_INDEX_MAX) ? `TCL_INDEX_MAX : adc_result;
  assign ofs_addr = `TCL_OFS_BASE + {2'b00, index_q, 1'b0};
  assign span_addr = `TCL_SPAN_BASE + {2'b00, index_q, 1'b0};
  assign cfg_addr = (step_q == 3'h0) ? `TCL_CFG1_ADDR :
                    (step_q == 3'h1) ? `TCL_CFG2_ADDR :
                    (step_q == 3'h2) ? `TCL_OTC_ADDR :
                    (step_q == 3'h3) ? `TCL_STC_ADDR : `TCL_PWRUP_ADDR;
  assign cfg_slot = (step_q == 3'h0) ? 3'h0 :
                    (step_q == 3'h1) ? 3'h1 :
                    (step_q == 3'h2) ? 3'h4 :
                    (step_q == 3'h3) ? 3'h5 : 3'h6;
  assign run_rise = ctrl_q[`TCL_CTRL_RUN] && !run_prev_q;
  assign reload_req = boot_q || run_rise;

  ////////////////////////////////////////////////////////////////////////////
  // loader state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= TCL_S_IDLE;
      step_q <= 3'h0;
      index_q <= 8'h00;
      rd_start_q <= 1'b0;
      rd_addr_q <= 11'h000;
      adc_start <= 1'b0;
      boot_q <= 1'b1;
      loaded_q <= 1'b0;
    end else begin
      rd_start_q <= 1'b0;
      adc_start <= 1'b0;
      case (state_q)
        TCL_S_IDLE: begin
          if (reload_req && ctrl_q[`TCL_CTRL_RUN]) begin
            boot_q <= 1'b0;
            step_q <= 3'h0;
            rd_addr_q <= `TCL_CFG1_ADDR;
            rd_start_q <= 1'b1;
            state_q <= TCL_S_CFG;
          end else if (tick && ctrl_q[`TCL_CTRL_RUN]) begin
            state_q <= TCL_S_ADC;
          end
        end
        TCL_S_CFG: begin
          if (rd_done && step_q == 3'h4) begin
            state_q <= TCL_S_ADC;
          end else if (rd_done) begin
            step_q <= step_q + 3'h1;
            state_q <= TCL_S_CFG;
          end
          if (rd_done && step_q != 3'h4) begin
            rd_start_q <= 1'b1;
          end
          rd_addr_q <= rd_done ? rd_addr_q : cfg_addr;
          if (rd_done && step_q != 3'h4) begin
            rd_addr_q <= (step_q == 3'h0) ? `TCL_CFG2_ADDR :
                         (step_q == 3'h1) ? `TCL_OTC_ADDR :
                         (step_q == 3'h2) ? `TCL_STC_ADDR : `TCL_PWRUP_ADDR;
          end
        end
        TCL_S_ADC: begin
          adc_start <= 1'b1;
          state_q <= TCL_S_ADCW;
        end
        TCL_S_ADCW: begin
          if (adc_done) begin
            index_q <= index_sat;
            state_q <= TCL_S_OFS;
            rd_start_q <= 1'b1;
          end
        end
        TCL_S_OFS: begin
          rd_addr_q <= ofs_addr;
          if (rd_done) begin
            rd_addr_q <= span_addr;
            rd_start_q <= 1'b1;
            state_q <= TCL_S_SPN;
          end
        end
        TCL_S_SPN: begin
          if (rd_done) begin
            loaded_q <= 1'b1;
            state_q <= TCL_S_IDLE;
          end
        end
        default: begin
          state_q <= TCL_S_IDLE;
        end
      endcase
      if (state_q == TCL_S_ADCW && adc_done) begin
        rd_addr_q <= `TCL_OFS_BASE + {2'b00, index_sat, 1'b0};
      end
      // reload asked for while busy waits for idle
      if (run_rise && state_q != TCL_S_IDLE) begin
        boot_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write and read
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic do_write;
  logic aw_hold_n;
  logic w_hold_n;
  logic bvalid_n;
  logic rvalid_n;
  logic wr_bank_hit;
  logic [2:0] wr_bank_idx;
  logic wr_mapped;
  logic rd_bank_hit;
  logic [2:0] rd_bank_idx;
  logic rd_mapped;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [15:0] wr_word16;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign aw_hs = s_axil_awvalid && s_axil_awready;
  assign w_hs = s_axil_wvalid && s_axil_wready;
  assign b_hs = s_axil_bvalid && s_axil_bready;
  assign ar_hs = s_axil_arvalid && s_axil_arready;
  assign r_hs = s_axil_rvalid && s_axil_rready;
  assign do_write = aw_hold_q && w_hold_q && !s_axil_bvalid;
  assign aw_hold_n = aw_hs ? 1'b1 : (do_write ? 1'b0 : aw_hold_q);
  assign w_hold_n = w_hs ? 1'b1 : (do_write ? 1'b0 : w_hold_q);
  assign bvalid_n = do_write ? 1'b1 : (b_hs ? 1'b0 : s_axil_bvalid);
  assign rvalid_n = ar_hs ? 1'b1 : (r_hs ? 1'b0 : s_axil_rvalid);

  assign wr_off = awaddr_q - `TCL_REG_BANK;
  assign wr_bank_hit = awaddr_q >= `TCL_REG_BANK && awaddr_q < `TCL_REG_INDEX
                       && awaddr_q[1:0] == 2'b00;
  assign wr_bank_idx = wr_off[4:2];
  assign wr_mapped = wr_bank_hit || awaddr_q == `TCL_REG_CTRL
                     || awaddr_q == `TCL_REG_STATUS || awaddr_q == `TCL_REG_INDEX;
  assign rd_off = s_axil_araddr - `TCL_REG_BANK;
  assign rd_bank_hit = s_axil_araddr >= `TCL_REG_BANK && s_axil_araddr < `TCL_REG_INDEX
                       && s_axil_araddr[1:0] == 2'b00;
  assign rd_bank_idx = rd_off[4:2];
  assign rd_mapped = rd_bank_hit || s_axil_araddr == `TCL_REG_CTRL
                     || s_axil_araddr == `TCL_REG_STATUS || s_axil_araddr == `TCL_REG_INDEX;
  assign status_word = {16'h0000, index_q, 5'h00, pin_sync_q, loaded_q,
                        state_q != TCL_S_IDLE};
  assign rd_mux = rd_bank_hit ? {16'h0000, bank_q[rd_bank_idx]} :
                  (s_axil_araddr == `TCL_REG_CTRL) ? {27'h0, ctrl_q} :
                  (s_axil_araddr == `TCL_REG_STATUS) ? status_word :
                  (s_axil_araddr == `TCL_REG_INDEX) ? {24'h0, index_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `TCL_RESP_OKAY;
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= `TCL_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_n;
      w_hold_q <= w_hold_n;
      s_axil_awready <= !aw_hold_n && !bvalid_n;
      s_axil_wready <= !w_hold_n && !bvalid_n;
      s_axil_bvalid <= bvalid_n;
      s_axil_arready <= !rvalid_n;
      s_axil_rvalid <= rvalid_n;
      if (aw_hs) begin
        awaddr_q <= s_axil_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
      if (do_write) begin
        s_axil_bresp <= wr_mapped ? `TCL_RESP_OKAY : `TCL_RESP_SLVERR;
      end
      if (ar_hs) begin
        s_axil_rdata <= rd_mux;
        s_axil_rresp <= rd_mapped ? `TCL_RESP_OKAY : `TCL_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank: cfg1, cfg2, offset, span, offset tc, span tc, power-up
  assign wr_word16 = {wstrb_q[1] ? wdata_q[15:8] : bank_q[wr_bank_idx][15:8],
                      wstrb_q[0] ? wdata_q[7:0] : bank_q[wr_bank_idx][7:0]};

  genvar gi;
  generate
    for (gi = 0; gi < `TCL_BANK_WORDS; gi++) begin : g_bank
      assign sw_we[gi] = do_write && wr_bank_hit && wr_bank_idx == 3'(gi);
      assign ld_we[gi] = rd_done && ((state_q == TCL_S_CFG && cfg_slot == 3'(gi))
                         || (state_q == TCL_S_OFS && gi == 2)
                         || (state_q == TCL_S_SPN && gi == 3));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          bank_q[gi] <= (gi == 1) ? `TCL_CFG2_RST : `TCL_WORD_RST;
        end else if (ld_we[gi]) begin
          bank_q[gi] <= rd_word;
        end else if (sw_we[gi]) begin
          bank_q[gi] <= wr_word16;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control, pin and analog settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `TCL_CTRL_RST;
      run_prev_q <= 1'b0;
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      shared_output_serial_pin_o <= 1'b0;
      shared_output_serial_pin_oe <= 1'b0;
      analog_output_en <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q[`TCL_CTRL_RUN];
      if (do_write && awaddr_q == `TCL_REG_CTRL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[4:0];
      end else begin
        ctrl_q[`TCL_CTRL_RELOAD] <= 1'b0;
      end
      if (ctrl_q[`TCL_CTRL_RELOAD]) begin
        run_prev_q <= 1'b0;
      end
      pin_meta_q <= shared_output_serial_pin_i;
      pin_sync_q <= pin_meta_q;
      shared_output_serial_pin_o <= ctrl_q[`TCL_CTRL_PIN_OUT];
      shared_output_serial_pin_oe <= ctrl_q[`TCL_CTRL_SERIAL]
                                     && ctrl_q[`TCL_CTRL_DRIVE];
      analog_output_en <= !ctrl_q[`TCL_CTRL_SERIAL];
    end
  end

  assign cfg1 = tcl_cfg1_t'(bank_q[0]);
  assign gain_step = cfg1.gain_step;
  assign swap_inputs = cfg1.swap_inputs;
  assign current_mirror_ratio_sel = cfg1.current_mirror_ratio_sel;
  assign span_tempco_to_excitation = cfg1.current_excitation;
  assign power_up_setup_word = bank_q[6];
  assign dac_codes = {bank_q[2], bank_q[3], bank_q[4], bank_q[5]};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_index_saturated: assert property (@(posedge aclk) disable iff (!aresetn)
    index_q <= `TCL_INDEX_MAX) else $error("index above saturation bound");
  chk_adc_to_index: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_ADCW && adc_done |=> index_q == $past(index_sat) && state_q == TCL_S_OFS)
    else $error("conversion result not stored as index");
  chk_tick_starts_adc: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_IDLE && tick && ctrl_q[0] && !reload_req |=> ##1 adc_start)
    else $error("refresh tick did not start a conversion");
  chk_offset_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_OFS && rd_done |=> dac_codes.offset_dac_code == $past(rd_word))
    else $error("offset code not loaded from table");
  chk_ofs_addr_range: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_OFS && flash_req |-> flash_addr <= `TCL_OFS_LAST
    && flash_addr[8:1] == index_q) else $error("offset read outside table");
  chk_span_addr_range: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_SPN && flash_req |-> flash_addr >= `TCL_SPAN_BASE
    && flash_addr <= `TCL_SPAN_LAST && flash_addr[8:1] == index_q)
    else $error("span read outside table");
  chk_user_untouched: assert property (@(posedge aclk) disable iff (!aresetn)
    flash_req |-> flash_addr < `TCL_USER_BASE) else $error("loader read user bytes");
  chk_no_byte_mix: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(dac_codes.span_dac_code) |-> $past(rd_done) || $past(sw_we[3]))
    else $error("span code changed without a whole word");
  chk_pin_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    shared_output_serial_pin_oe |-> !analog_output_en) else $error("pin driven in analog mode");
  chk_cfg1_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_CFG && step_q == 3'h0 && rd_done |=> bank_q[0] == $past(rd_word))
    else $error("first config word not loaded");
  cov_boot_load: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_CFG && step_q == 3'h4 && rd_done);
  cov_refresh_done: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_SPN && rd_done);
  cov_index_clamped: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == TCL_S_ADCW && adc_done && adc_result > `TCL_INDEX_MAX);
  cov_sw_tempco: cover property (@(posedge aclk) disable iff (!aresetn) sw_we[4]);
  cov_reload_deferred: cover property (@(posedge aclk) disable iff (!aresetn)
    run_rise && state_q != TCL_S_IDLE);
endmodule

// ===== design/tcl_pkg.sv
// types of the calibration loader
package tcl_pkg;
  typedef enum logic [2:0] {
    TCL_S_IDLE = 3'b000,
    TCL_S_CFG = 3'b001,
    TCL_S_ADC = 3'b010,
    TCL_S_ADCW = 3'b011,
    TCL_S_OFS = 3'b100,
    TCL_S_SPN = 3'b101
  } tcl_state_t;

  typedef struct packed {
    logic [6:0] reserved;
    logic current_excitation;
    logic [1:0] current_mirror_ratio_sel;
    logic swap_inputs;
    logic [4:0] gain_step;
  } tcl_cfg1_t;

  typedef struct packed {
    logic [15:0] offset_dac_code;
    logic [15:0] span_dac_code;
    logic [15:0] offset_tempco_dac_code;
    logic [15:0] span_tempco_dac_code;
  } tcl_dac_codes_t;
endpackage

// ===== design/tcl_refresh_timer.sv
// refresh interval timer, one tick per interval
`timescale 1ns/1ps
module tcl_refresh_timer import tcl_pkg::*; #(
  parameter int unsigned UNIT_CYC = 200000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [1:0] sel,
  // event
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] period;
  logic at_end;

  // interval is the unit doubled sel times
  assign period = UNIT_CYC << sel;
  assign at_end = (cnt_q >= period - 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || at_end) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && at_end;
    end
  end
endmodule

// ===== dv/tcl_far_side_model.sv
// flash and temperature adc model facing the calibration loader
`timescale 1ns/1ps
module tcl_far_side_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // flash byte port
  input wire logic flash_req,
  input wire logic [10:0] flash_addr,
  output logic [7:0] flash_rdata,
  output logic flash_ack,
  // temperature adc
  input wire logic adc_start,
  output logic adc_done,
  output logic [7:0] adc_result,
  // scenario control
  input wire logic [7:0] temp_code,
  input wire logic [2:0] lat
);
  logic [3:0] fcnt_q;
  logic [3:0] acnt_q;
  logic busy_q;
  // odd byte differs from even byte in bit 0
  function automatic logic [7:0] fbyte(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], a[10:8], 2'h0};
  endfunction
  initial begin
    flash_rdata = 8'hA5;
    flash_ack = 1'h0;
    adc_done = 1'h0;
    adc_result = 8'h5A;
  end
  ////////////////////////////////////////
  // released lines invert every cycle
  always @(posedge aclk) begin
    flash_ack <= 1'h0;
    flash_rdata <= ~flash_rdata;
    if (!aresetn || !flash_req || flash_ack) begin
      fcnt_q <= 4'h0;
    end else if (fcnt_q >= {1'h0, lat}) begin
      flash_ack <= 1'h1;
      flash_rdata <= fbyte(flash_addr);
    end else begin
      fcnt_q <= fcnt_q + 4'h1;
    end
  end
  always @(posedge aclk) begin
    adc_done <= 1'h0;
    adc_result <= ~adc_result;
    if (!aresetn) begin
      busy_q <= 1'h0;
    end else if (adc_start) begin
      busy_q <= 1'h1;
      acnt_q <= {1'h0, lat};
    end else if (busy_q && acnt_q == 4'h0) begin
      busy_q <= 1'h0;
      adc_done <= 1'h1;
      adc_result <= temp_code;
    end else if (busy_q) begin
      acnt_q <= acnt_q - 4'h1;
    end
  end
endmodule

// ===== dv/tcl_loader_tb_top.sv
// self-checking bench of the calibration loader
`timescale 1ns/1ps
module tcl_loader_tb_top import tcl_pkg::*; ;
  logic aclk = '0, aresetn = '0, pin_i = '0;
  logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0, temp_code = '0;
  logic [31:0] s_axil_wdata = '0, s_axil_rdata, rnd = 32'hE8EE;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic s_axil_awvalid = '0, s_axil_wvalid = '0, s_axil_bready = '0;
  logic s_axil_arvalid = '0, s_axil_rready = '0, s_axil_rvalid, s_axil_bvalid;
  logic s_axil_awready, s_axil_wready, s_axil_arready;
  logic [1:0] s_axil_bresp, s_axil_rresp, current_mirror_ratio_sel;
  logic flash_req, flash_ack, adc_start, adc_done, swap_inputs, span_tempco_to_excitation;
  logic [10:0] flash_addr;
  logic [7:0] flash_rdata, adc_result, fixed[4] = '{8'hAF, 8'hB0, 8'hFF, 8'hAE};
  logic [2:0] lat = '0;
  logic [4:0] gain_step;
  logic [15:0] power_up_setup_word;
  logic shared_output_serial_pin_o, shared_output_serial_pin_oe, analog_output_en;
  tcl_dac_codes_t dac_codes;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [8:0] v;
  int n_errors = 0, cmp_count = 0;
  always #2.5 aclk = ~aclk;
  tcl_loader #(.REFRESH_UNIT_CYC(20)) dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .flash_req, .flash_addr, .flash_rdata, .flash_ack, .adc_start, .adc_done, .adc_result,
    .dac_codes, .gain_step, .swap_inputs, .current_mirror_ratio_sel, .span_tempco_to_excitation,
    .power_up_setup_word, .shared_output_serial_pin_i(pin_i), .shared_output_serial_pin_o,
    .shared_output_serial_pin_oe, .analog_output_en);
  tcl_far_side_model far (.aclk, .aresetn, .flash_req, .flash_addr, .flash_rdata, .flash_ack,
    .adc_start, .adc_done, .adc_result, .temp_code, .lat);
  ////////////////////////////////////////
  function automatic logic [15:0] fw(input logic [10:0] a);
    return {a[7:0] ^ {a[10:8], a[10:8], 2'h1}, a[7:0] ^ {a[10:8], a[10:8], 2'h0}};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wq.push_back(r);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wready) s_axil_wvalid <= 1'h0;
    end while (!s_axil_bvalid);
    s_axil_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'h0;
    end while (!s_axil_rvalid);
    s_axil_rready <= 1'h0;
    @(posedge aclk);
  endtask
  // one refresh at a new temperature code, then both table words
  task automatic run_temp(input logic [7:0] t);
    logic [7:0] idx;
    idx = (t > 8'hAF) ? 8'hAF : t;
    temp_code <= t;
    do @(posedge aclk); while (!adc_start);
    repeat (2) begin
      do @(posedge aclk); while (!flash_req);
      do @(posedge aclk); while (flash_req);
    end
    repeat (2) @(posedge aclk);
    #1;
    chk(dac_codes.offset_dac_code,
      fw({2'h0, idx, 1'h0}));
    chk(dac_codes.span_dac_code, fw({2'h1, idx, 1'h0}));
    axi_rd(8'h24, {26'h0, idx});
  endtask
  ////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axil_rvalid && s_axil_rready) chk({s_axil_rresp, s_axil_rdata}, rq.pop_front());
    if (s_axil_bvalid && s_axil_bready) chk(s_axil_bresp, wq.pop_front());
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    run_temp(8'h00);
    chk({span_tempco_to_excitation, current_mirror_ratio_sel, swap_inputs, gain_step},
      fw(11'h160) & 16'h01FF);
    chk({dac_codes.offset_tempco_dac_code, dac_codes.span_tempco_dac_code, power_up_setup_word},
      {fw(11'h166), fw(11'h16A), fw(11'h16C)});
    axi_rd(8'h0C, {18'h0, fw(11'h162)});
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      lat <= rnd[2:0];
      pin_i <= rnd[3];
      run_temp(i < 4 ? fixed[i] : rnd[15:8]);
    end
    axi_wr(8'h18, 32'h0000FFFF, 2'h0);
    axi_wr(8'h1C, 32'hFFFF0000, 2'h0);
    axi_rd(8'h18, {18'h0, 16'hFFFF});
    axi_rd(8'h1C, 34'h0);
    chk({dac_codes.offset_tempco_dac_code, dac_codes.span_tempco_dac_code},
      32'hFFFF0000);
    for (int r = 0; r < 4; r++) begin
      rnd = lfsr(rnd);
      v = {rnd[8], r[1:0], rnd[5:0]};
      axi_wr(8'h08, {23'h0, v}, 2'h0);
      repeat (2) @(posedge aclk);
      #1;
      chk({span_tempco_to_excitation, current_mirror_ratio_sel, swap_inputs, gain_step},
        v);
    end
    // reload bit brings config and tempco words back from flash
    axi_wr(8'h00, 32'h00000011, 2'h0);
    repeat (400) @(posedge aclk);
    #1;
    chk({7'h0, span_tempco_to_excitation, current_mirror_ratio_sel, swap_inputs, gain_step,
      dac_codes.offset_tempco_dac_code, dac_codes.span_tempco_dac_code},
      {fw(11'h160) & 16'h01FF, fw(11'h166), fw(11'h16A)});
    axi_wr(8'h28, 32'h00001234, 2'h2);
    axi_rd(8'h28, {2'h2, 32'h0});
    axi_wr(8'h00, 32'h0000000F, 2'h0);
    repeat (3) @(posedge aclk);
    #1;
    chk({shared_output_serial_pin_oe, shared_output_serial_pin_o, analog_output_en}, 3'h6);
    axi_wr(8'h00, 32'h00000001, 2'h0);
    repeat (3) @(posedge aclk);
    #1;
    chk({shared_output_serial_pin_oe, shared_output_serial_pin_o, analog_output_en}, 3'h1);
    // stopped and idle: status shows index, pin level, loaded, not busy
    axi_wr(8'h00, 32'h00000000, 2'h0);
    repeat (100) @(posedge aclk);
    axi_rd(8'h04, {18'h0, (temp_code > 8'hAF) ? 8'hAF : temp_code, 5'h0, pin_i,
      2'h2});
    tally_and_finish;
  end
endmodule
